// file: src/dssw_defs.svh
// constants for the drive state status word block
`ifndef DSSW_DEFS_SVH
`define DSSW_DEFS_SVH
// state word bit positions
`define DSSW_B_RDY      0
`define DSSW_B_SWON     1
`define DSSW_B_OPEN     2
`define DSSW_B_FAULT    3
`define DSSW_B_VOLT     4
`define DSSW_B_QSTOP_N  5
`define DSSW_B_SODIS    6
`define DSSW_B_WARN     7
`define DSSW_B_REMOTE   9
`define DSSW_B_REACHED  10
`define DSSW_B_LIMIT    11
`define DSSW_B_STOPKEY  14
`define DSSW_B_DIR      15
// control word bit positions
`define DSSW_C_SWON     0
`define DSSW_C_ENV      1
`define DSSW_C_QS       2
`define DSSW_C_ENOP     3
`define DSSW_C_FRST     7
// state decode mask
`define DSSW_STATE_MASK 16'h006F
// reset value of the state word
`define DSSW_WORD_RST   16'h0000
// supply timeout, milliseconds, and clock rate
`define DSSW_SUPPLY_TO_MS 1000
`define DSSW_CLK_HZ       20000000
// fault reaction terminal count; the reaction state lasts this many cycles plus one
`define DSSW_REACT_CYC    16'h0010
`endif

// file: src/dssw_pkg.sv
// types of the drive state status word block
package dssw_pkg;
  typedef enum logic [7:0] {
    ST_NOT_READY = 8'h01,
    ST_SO_DIS    = 8'h02,
    ST_READY     = 8'h04,
    ST_SWON      = 8'h08,
    ST_OPEN      = 8'h10,
    ST_QSTOP     = 8'h20,
    ST_REACT     = 8'h40,
    ST_FAULT     = 8'h80
  } dssw_state_t;
  typedef struct packed {
    logic supply_ok;
    logic fault_cause;
    logic warning;
    logic remote;
    logic ref_reached;
    logic ref_limit;
    logic stop_key;
    logic dir_reverse;
    logic mains_ctl_mode;
  } dssw_sense_t;
endpackage

// file: src/dssw_timer.sv
// down counter that pulses once when its load expires
`timescale 1ns/1ps
`include "dssw_defs.svh"
module dssw_timer #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // control
  input  wire logic         run,
  input  wire logic [W-1:0] load,
  // result
  output logic              expired
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         exp;
  } dssw_tmr_t;
  dssw_tmr_t s_q;
  dssw_tmr_t s_d;
  always_comb begin
    s_d = s_q;
    s_d.exp = 1'b0;
    if (!run) begin
      s_d.cnt = load;
    end else if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - W'(1);
      s_d.exp = (s_q.cnt == W'(1));
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign expired = s_q.exp;
endmodule

// file: src/dssw_core.sv
// drive operating state machine and status word encoder
`timescale 1ns/1ps
`include "dssw_defs.svh"
module dssw_core
  import dssw_pkg::*;
#(
  parameter int SUPPLY_TO_MS = `DSSW_SUPPLY_TO_MS
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // fieldbus control word and drive sense
  input  wire logic [15:0] control_word,
  input  wire dssw_sense_t sense,
  input  wire logic        init_done,
  // status
  output logic [15:0]      drive_state_word,
  output logic             mains_contactor_close,
  output logic             contactor_error,
  output logic             awaiting_supply_display,
  output logic             motor_power
);
  localparam int SUPPLY_TO_CYC = SUPPLY_TO_MS * (`DSSW_CLK_HZ / 1000);

  typedef struct packed {
    dssw_state_t st;
    logic        frst_prev;
    logic        from_qstop;
    logic        cont_close;
    logic        cont_err;
    logic [15:0] react_cnt;
    logic [15:0] word;
  } dssw_core_s_t;

  dssw_core_s_t s_q;
  dssw_core_s_t s_d;
  logic         to_run;
  logic         to_exp;
  logic         c_env;
  logic         c_qs;
  logic         c_swon;
  logic         c_enop;
  logic         frst_rise;
  logic         shutdown_cmd;
  logic         swon_cmd;
  logic         enop_cmd;
  logic         fault_in;
  logic [15:0]  w;

  // ==========================================
  // supply timeout in switched on
  assign to_run = (s_q.st == ST_SWON) && !sense.supply_ok;
  dssw_timer #(.W(32)) u_timer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .run     (to_run),
    .load    (32'(SUPPLY_TO_CYC)),
    .expired (to_exp)
  );

  // ==========================================
  // command decode
  assign c_swon       = control_word[`DSSW_C_SWON];
  assign c_env        = control_word[`DSSW_C_ENV];
  assign c_qs         = control_word[`DSSW_C_QS];
  assign c_enop       = control_word[`DSSW_C_ENOP];
  assign frst_rise    = control_word[`DSSW_C_FRST] && !s_q.frst_prev;
  assign shutdown_cmd = c_env && c_qs && !c_swon;
  assign swon_cmd     = c_env && c_qs && c_swon && !c_enop;
  assign enop_cmd     = c_env && c_qs && c_swon && c_enop;
  assign fault_in     = sense.fault_cause || to_exp;

  // ==========================================
  // state machine
  always_comb begin
    s_d = s_q;
    s_d.frst_prev = control_word[`DSSW_C_FRST];
    if (to_exp) begin
      s_d.cont_err = 1'b1;
    end
    case (s_q.st)
      ST_NOT_READY: begin
        if (init_done) begin
          s_d.st = ST_SO_DIS;
        end
      end
      ST_SO_DIS: begin
        if (shutdown_cmd) begin
          s_d.st = ST_READY;
        end
      end
      ST_READY: begin
        if (!c_env) begin
          s_d.st = ST_SO_DIS;
        end else if (swon_cmd || enop_cmd) begin
          s_d.st = ST_SWON;
          s_d.cont_close = 1'b1;
        end
      end
      ST_SWON: begin
        if (fault_in) begin
          s_d.st = ST_REACT;
        end else if (!c_env) begin
          s_d.st = ST_SO_DIS;
        end else if (shutdown_cmd) begin
          s_d.st = ST_READY;
        end else if (enop_cmd && sense.supply_ok) begin
          s_d.st = ST_OPEN;
        end
      end
      ST_OPEN: begin
        if (fault_in) begin
          s_d.st = ST_REACT;
        end else if (!c_env) begin
          s_d.st = ST_SO_DIS;
        end else if (!c_qs) begin
          s_d.st = ST_QSTOP;
        end else if (shutdown_cmd) begin
          s_d.st = ST_READY;
        end else if (swon_cmd) begin
          s_d.st = ST_SWON;
        end
      end
      ST_QSTOP: begin
        if (fault_in) begin
          s_d.st = ST_REACT;
          s_d.from_qstop = 1'b1;
        end else if (!c_env) begin
          s_d.st = ST_SO_DIS;
        end
      end
      ST_REACT: begin
        s_d.react_cnt = s_q.react_cnt + 16'h0001;
        if (s_q.react_cnt == `DSSW_REACT_CYC) begin
          s_d.st = ST_FAULT;
          s_d.react_cnt = 16'h0000;
        end
      end
      ST_FAULT: begin
        if (frst_rise && !sense.fault_cause) begin
          s_d.st = ST_SO_DIS;
          s_d.from_qstop = 1'b0;
          s_d.cont_err = to_exp;
        end
      end
      default: begin
        s_d.st = ST_NOT_READY;
      end
    endcase
    // contactor open in the not ready, switch on disabled, ready and fault states
    if (s_d.st == ST_NOT_READY || s_d.st == ST_SO_DIS || s_d.st == ST_READY ||
        s_d.st == ST_FAULT) begin
      s_d.cont_close = 1'b0;
    end

    // ==========================================
    // status word encode
    w = 16'h0000;
    w[`DSSW_B_VOLT]    = sense.supply_ok;
    w[`DSSW_B_WARN]    = sense.warning;
    w[`DSSW_B_REMOTE]  = sense.remote;
    w[`DSSW_B_REACHED] = sense.ref_reached;
    w[`DSSW_B_LIMIT]   = sense.ref_limit;
    w[`DSSW_B_STOPKEY] = sense.stop_key;
    w[`DSSW_B_DIR]     = sense.dir_reverse;
    w[`DSSW_B_QSTOP_N] = 1'b1;
    case (s_d.st)
      ST_SO_DIS: begin
        w[`DSSW_B_SODIS] = 1'b1;
        w[`DSSW_B_QSTOP_N] = 1'b0;
      end
      ST_READY: begin
        w[`DSSW_B_RDY] = 1'b1;
      end
      ST_SWON: begin
        w[`DSSW_B_RDY] = 1'b1;
        w[`DSSW_B_SWON] = 1'b1;
      end
      ST_OPEN: begin
        w[2:0] = 3'h7;
      end
      ST_QSTOP: begin
        w[2:0] = 3'h7;
        w[`DSSW_B_QSTOP_N] = 1'b0;
      end
      ST_REACT: begin
        w[3:0] = 4'hF;
      end
      ST_FAULT: begin
        w[`DSSW_B_FAULT] = 1'b1;
        w[`DSSW_B_QSTOP_N] = s_d.from_qstop;
      end
      default: begin
        w[`DSSW_B_QSTOP_N] = 1'b0;
      end
    endcase
    s_d.word = w;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '{st: ST_NOT_READY, word: `DSSW_WORD_RST, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================
  // outputs
  assign drive_state_word        = s_q.word;
  assign mains_contactor_close   = s_q.cont_close && sense.mains_ctl_mode;
  assign contactor_error         = s_q.cont_err;
  assign awaiting_supply_display = (s_q.st == ST_READY) && !sense.supply_ok;
  assign motor_power             = (s_q.st == ST_OPEN) || (s_q.st == ST_QSTOP);
endmodule

// file: bench/dssw_asserts.sv
// concurrent checks on the status word core ports
`timescale 1ns/1ps
module dssw_asserts
  import dssw_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // inputs watched
  input wire logic [15:0] control_word,
  input wire dssw_sense_t sense,
  // outputs watched
  input wire logic [15:0] drive_state_word,
  input wire logic        mains_contactor_close,
  input wire logic        contactor_error,
  input wire logic        awaiting_supply_display,
  input wire logic        motor_power
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic [15:0] w = drive_state_word;
  // ==========================================
  // fault state decode
  sequence s_in_fault;
    (w & 16'h004F) == 16'h0008;
  endsequence
  sequence s_no_reset;
    !$rose(control_word[7]) || sense.fault_cause;
  endsequence
  // switch on or enable operation seen in ready
  sequence s_swon_in_ready;
    (w & 16'h006F) == 16'h0021 && control_word[2:0] == 3'h7;
  endsequence
  // ==========================================
  // checks
  a_rsv_zero: assert property (w[8] == 1'b0 && w[13:12] == 2'b00)
    else $error("reserved status bits set");
  a_sodis_excl: assert property (w[6] |-> w[3:0] == 4'h0)
    else $error("disabled shows other state bits");
  a_err_fault: assert property ($rose(contactor_error) |-> ##[0:2] w[3])
    else $error("contactor error without fault");
  a_close_mode: assert property (s_swon_in_ready |=>
      mains_contactor_close || !sense.mains_ctl_mode)
    else $error("contactor not closed by switch on");
  a_close_open: assert property ((w & 16'h006F) == 16'h0021 |-> !mains_contactor_close)
    else $error("contactor closed in ready");
  a_await_ready: assert property (awaiting_supply_display |-> (w & 16'h006F) == 16'h0021)
    else $error("supply display outside ready");
  a_motor_pow: assert property (motor_power |-> w[2:0] == 3'b111)
    else $error("motor power outside running states");
  a_frst_edge: assert property (s_in_fault ##0 s_no_reset |=> w[3])
    else $error("fault left without reset edge");
endmodule
bind dssw_core dssw_asserts u_chk (
  .clk_sys(clk_sys), .rst(rst), .control_word(control_word), .sense(sense),
  .drive_state_word(drive_state_word), .mains_contactor_close(mains_contactor_close),
  .contactor_error(contactor_error), .awaiting_supply_display(awaiting_supply_display),
  .motor_power(motor_power));

// file: bench/dssw_master.sv
// fieldbus master model: encodes sequencer commands as control words
`timescale 1ns/1ps
module dssw_master (
  // command code: idle, shutdown, switch on, enable, quick stop, fault reset
  input  wire logic [2:0]  code,
  // control word to the drive
  output logic      [15:0] control_word
);
  localparam logic [15:0] CW [6] = '{16'h0000, 16'h0006, 16'h0007,
                                     16'h000F, 16'h0002, 16'h0080};
  // sequence order is chosen by the caller per supply arrangement
  assign control_word = (code < 3'h6) ? CW[code] : 16'h0000;
endmodule

// file: bench/tb_top.sv
// self-checking bench for the status word core
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected at %0t: got %h exp %h", $time, (a), (b)); end end
module tb_top;
  import dssw_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        init_done = 1'b0;
  logic [2:0]  code = 3'h0;
  dssw_sense_t sense = '0;
  logic [15:0] control_word;
  logic [15:0] drive_state_word;
  logic        mains_contactor_close;
  logic        contactor_error;
  logic        awaiting_supply_display;
  logic        motor_power;
  logic [39:0] exp_q[$];
  logic [39:0] e;
  logic [19:0] got;
  logic [15:0] rs;
  int          miscompares = 0;
  int          n_checks = 0;
  int          cyc = 0;
  dssw_master u_master (.code(code), .control_word(control_word));
  dssw_core #(.SUPPLY_TO_MS(1)) uut (
    .clk_sys(clk_sys), .rst(rst), .control_word(control_word), .sense(sense),
    .init_done(init_done), .drive_state_word(drive_state_word),
    .mains_contactor_close(mains_contactor_close), .contactor_error(contactor_error),
    .awaiting_supply_display(awaiting_supply_display), .motor_power(motor_power));
  initial forever #25 clk_sys = ~clk_sys;
  task automatic finish_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // one command per cycle; note {mask, value} of motor, await, error, close, word
  task automatic step(input logic [2:0] c, input logic [19:0] m, input logic [19:0] x);
    code = c;
    if (m !== 20'h0) exp_q.push_back({m, x});
    @(negedge clk_sys);
  endtask
  // ==========================================
  // result monitor and hang guard
  always @(posedge clk_sys) begin
    #1;
    if (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      got = {motor_power, awaiting_supply_display, contactor_error, mains_contactor_close,
             drive_state_word};
      `CHK(got & e[39:20], e[19:0])
    end
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 25000) begin
      miscompares++;
      finish_test();
    end
  end
  // ==========================================
  // scenarios
  initial begin
    void'($urandom(32'h703e));
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    init_done = 1'b1;
    step(3'h0, 20'hF006F, 20'h00040);
    rs = 16'($urandom());
    sense = dssw_sense_t'({2'b00, rs[5:0], 1'b0});
    step(3'h0, 20'h0FFCF, {4'h0, rs[0], rs[1], 2'b00, rs[2], rs[3], rs[4],
                           1'b0, rs[5], 7'h40});
    // shared supply: shutdown, check ready, enable operation directly
    sense = '0;
    step(3'h1, 20'hC00FF, 20'h40021);
    sense.supply_ok = 1'b1;
    step(3'h1, 20'hC00FF, 20'h00031);
    step(3'h3, 20'hC006F, 20'h00023);
    step(3'h3, 20'hC006F, 20'h80027);
    step(3'h4, 20'hC006F, 20'h80007);
    sense.fault_cause = 1'b1;
    step(3'h4, 20'hC004F, 20'h0000F);
    repeat (20) step(3'h4, 20'h0, 20'h0);
    step(3'h5, 20'hF006F, 20'h00028);
    sense.fault_cause = 1'b0;
    step(3'h5, 20'hF006F, 20'h00028);
    step(3'h0, 20'h0, 20'h0);
    step(3'h5, 20'hF006F, 20'h00040);
    // separate control stage: confirm supply, then switched on, then enable
    sense.supply_ok = 1'b0;
    step(3'h1, 20'hC00FF, 20'h40021);
    sense.supply_ok = 1'b1;
    step(3'h1, 20'hC00FF, 20'h00031);
    step(3'h2, 20'hC006F, 20'h00023);
    step(3'h3, 20'hC006F, 20'h80027);
    step(3'h2, 20'hC006F, 20'h00023);
    step(3'h0, 20'hC006F, 20'h00040);
    // drive switches its own mains contactor
    sense = dssw_sense_t'(9'h001);
    step(3'h1, 20'h5006F, 20'h40021);
    step(3'h2, 20'h9006F, 20'h10023);
    step(3'h1, 20'h5006F, 20'h40021);
    step(3'h2, 20'h9006F, 20'h10023);
    // supply never arrives: enable refused, timeout is 20000 cycles at 1 ms
    step(3'h3, 20'h9006F, 20'h10023);
    repeat (20039) step(3'h3, 20'h0, 20'h0);
    step(3'h3, 20'hF004F, 20'h20008);
    @(negedge clk_sys);
    finish_test();
  end
endmodule
